// >>> logic/tdc_pkg.sv
// Constants for the terminal run-command decoder.
// Assumes a 25 MHz controller clock and an Avalon-MM register slave.
package tdc_pkg;
    localparam int          CLK_HZ         = 25_000_000;
    localparam int          DELAY_UNIT_MS  = 100;
    localparam int          RAMP_STEP_MS   = 1;
    localparam int          DELAY_CYCLES   = CLK_HZ / 1000 * DELAY_UNIT_MS;
    localparam int          RAMP_CYCLES    = CLK_HZ / 1000 * RAMP_STEP_MS;
    localparam int          NUM_INPUTS     = 10;
    localparam int          NUM_DELAYED    = 5;
    localparam logic [14:0] DELAY_MAX      = 15'h7530;
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_RATE       = 8'h04;
    localparam logic [7:0]  OFF_POL_LO     = 8'h08;
    localparam logic [7:0]  OFF_POL_HI     = 8'h0C;
    localparam logic [7:0]  OFF_STATUS     = 8'h10;
    localparam logic [7:0]  OFF_FREQ       = 8'h14;
    localparam logic [7:0]  OFF_DELAY_BASE = 8'h20;
    localparam logic [7:0]  OFF_DELAY_LAST = 8'h44;
    localparam int          CTRL_MODE_LSB  = 0;
    localparam int          CTRL_RES_LSB   = 4;
    localparam int          STAT_RUN_BIT   = 0;
    localparam int          STAT_REV_BIT   = 1;
    localparam int          STAT_LVL_LSB   = 16;
    localparam logic [1:0]  MODE_RST       = 2'h0;
    localparam logic [1:0]  RES_RST        = 2'h2;
    localparam logic [1:0]  RES_COARSE     = 2'h1;
    localparam logic [15:0] RATE_RST       = 16'h03E8;
    localparam logic [4:0]  POL_RST        = 5'h00;
    localparam logic [14:0] DELAY_RST      = 15'h0000;
    localparam logic [31:0] FREQ_MAX_RST   = 32'h02FA_F080;
    typedef enum logic [1:0] {
        TDC_TWO_LINE_1,
        TDC_TWO_LINE_2,
        TDC_THREE_LINE_1,
        TDC_THREE_LINE_2
    } tdc_mode_t;
endpackage

// >>> logic/tdc_terminal_decoder.sv
// Terminal run-command decoder with Avalon-MM register slave.
// Assumes din_i come straight from contact pins, asynchronous to ref_clk_i.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module tdc_terminal_decoder
    import tdc_pkg::*;
#(
    parameter int          DELAY_TICK_CYCLES = DELAY_CYCLES,
    parameter int          RAMP_TICK_CYCLES  = RAMP_CYCLES,
    parameter logic [31:0] FREQ_MAX_UHZ      = FREQ_MAX_RST
) (
    input  wire logic                  ref_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic [NUM_INPUTS-1:0] din_i,
    input  wire logic [7:0]            avs_address_i,
    input  wire logic                  avs_read_i,
    input  wire logic                  avs_write_i,
    input  wire logic [31:0]           avs_writedata_i,
    input  wire logic [3:0]            avs_byteenable_i,
    output logic      [31:0]           avs_readdata_o,
    output logic                       avs_waitrequest_o,
    output logic                       run_o,
    output logic                       reverse_o,
    output logic      [31:0]           freq_ref_o
);
    if (DELAY_TICK_CYCLES < 1 || DELAY_TICK_CYCLES > 33554431) begin : g_chk_delay
        $error("DELAY_TICK_CYCLES out of range");
    end
    if (RAMP_TICK_CYCLES < 1 || RAMP_TICK_CYCLES > 33554431) begin : g_chk_ramp
        $error("RAMP_TICK_CYCLES out of range");
    end
    if (NUM_DELAYED > NUM_INPUTS
        || OFF_DELAY_BASE + 8'(8 * NUM_DELAYED - 4) != OFF_DELAY_LAST) begin : g_chk_map
        $error("Delay slots do not match the register map");
    end

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = wdata[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [14:0] clip_delay(input logic [31:0] v);
        logic [14:0] res;
        res = (v[31:15] != 17'h0 || v[14:0] > DELAY_MAX) ? DELAY_MAX : v[14:0];
        return res;
    endfunction

    // Register file
    logic [1:0]  mode_q;
    logic [1:0]  res_q;
    logic [15:0] rate_q;
    logic [4:0]  pol_lo_q;
    logic [4:0]  pol_hi_q;
    logic [14:0] on_dly_q  [NUM_DELAYED];
    logic [14:0] off_dly_q [NUM_DELAYED];
    logic [31:0] readdata_d;
    logic [31:0] wr_ctrl;
    logic [31:0] wr_word;
    logic [31:0] wr_rate;
    logic [14:0] dly_cur;
    logic        wr_fire;
    logic        dly_hit;
    logic [2:0]  dly_idx;
    logic        dly_off_sel;
    logic [7:0]  dly_rel;

    // Conditioning chain
    logic [NUM_INPUTS-1:0] sync1_q;
    logic [NUM_INPUTS-1:0] sync2_q;
    logic [NUM_INPUTS-1:0] active;
    logic [NUM_INPUTS-1:0] lvl_q;
    logic [14:0]           dly_cnt_q [NUM_DELAYED];
    logic [24:0]           dtick_cnt_q;
    logic                  dtick_q;
    logic [24:0]           rtick_cnt_q;
    logic                  rtick_q;

    // Decoder
    logic       fwd_prev_q;
    logic       rev_prev_q;
    logic       latch_run_q;
    logic       latch_rev_q;
    logic       run_d;
    logic       rev_d;
    logic [19:0] step;
    logic [32:0] freq_up;

    assign wr_fire     = avs_write_i && !avs_waitrequest_o;
    assign dly_rel     = avs_address_i - OFF_DELAY_BASE;
    assign dly_hit     = avs_address_i >= OFF_DELAY_BASE && avs_address_i <= OFF_DELAY_LAST
                         && avs_address_i[1:0] == 2'h0;
    assign dly_idx     = dly_rel[5:3];
    assign dly_off_sel = dly_rel[2];
    // Zero outside the delay slots, so the array is never read past its end
    assign dly_cur     = !dly_hit ? 15'h0000
                       : (dly_off_sel ? off_dly_q[dly_idx] : on_dly_q[dly_idx]);

    // One wait cycle, then a one-cycle acknowledge
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_comb begin
        readdata_d = 32'h0000_0000;
        case (avs_address_i)
            OFF_CTRL: begin
                readdata_d[CTRL_MODE_LSB +: 2] = mode_q;
                readdata_d[CTRL_RES_LSB +: 2]  = res_q;
            end
            OFF_RATE:   readdata_d[15:0] = rate_q;
            OFF_POL_LO: readdata_d[4:0]  = pol_lo_q;
            OFF_POL_HI: readdata_d[4:0]  = pol_hi_q;
            OFF_STATUS: begin
                readdata_d[STAT_RUN_BIT] = run_o;
                readdata_d[STAT_REV_BIT] = reverse_o;
                readdata_d[STAT_LVL_LSB +: NUM_INPUTS] = lvl_q;
            end
            OFF_FREQ: readdata_d = freq_ref_o;
            default: begin
                if (dly_hit) begin
                    readdata_d[14:0] = dly_cur;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && avs_waitrequest_o) begin
            avs_readdata_o <= readdata_d;
        end
    end

    assign wr_ctrl = be_merge({26'h0, res_q, 2'h0, mode_q}, avs_writedata_i, avs_byteenable_i);
    assign wr_word = be_merge({17'h0, dly_cur}, avs_writedata_i, avs_byteenable_i);
    assign wr_rate = be_merge({16'h0, rate_q}, avs_writedata_i, avs_byteenable_i);

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mode_q <= MODE_RST;
            res_q  <= RES_RST;
        end else if (wr_fire && avs_address_i == OFF_CTRL) begin
            mode_q <= wr_ctrl[CTRL_MODE_LSB +: 2];
            res_q  <= wr_ctrl[CTRL_RES_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rate_q <= RATE_RST;
        end else if (wr_fire && avs_address_i == OFF_RATE) begin
            rate_q <= wr_rate[15:0];
        end
    end

    // Polarity digits change only through byte lane 0
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pol_lo_q <= POL_RST;
            pol_hi_q <= POL_RST;
        end else if (wr_fire && avs_byteenable_i[0]) begin
            if (avs_address_i == OFF_POL_LO) begin
                pol_lo_q <= avs_writedata_i[4:0];
            end
            if (avs_address_i == OFF_POL_HI) begin
                pol_hi_q <= avs_writedata_i[4:0];
            end
        end
    end

    // Writes above 3000.0 s saturate instead of wrapping
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            for (int k = 0; k < NUM_DELAYED; k++) begin
                on_dly_q[k]  <= DELAY_RST;
                off_dly_q[k] <= DELAY_RST;
            end
        end else if (wr_fire && dly_hit) begin
            if (dly_off_sel) begin
                off_dly_q[dly_idx] <= clip_delay(wr_word);
            end else begin
                on_dly_q[dly_idx] <= clip_delay(wr_word);
            end
        end
    end

    // Contacts are asynchronous to the clock
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= din_i;
            sync2_q <= sync1_q;
        end
    end

    // din high means closed to common
    assign active = ~(sync2_q ^ {pol_hi_q, pol_lo_q});

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            dtick_cnt_q <= 25'h0;
            dtick_q     <= 1'b0;
        end else if (dtick_cnt_q == 25'(DELAY_TICK_CYCLES - 1)) begin
            dtick_cnt_q <= 25'h0;
            dtick_q     <= 1'b1;
        end else begin
            dtick_cnt_q <= dtick_cnt_q + 25'h1;
            dtick_q     <= 1'b0;
        end
    end

    // Free-running tick: a delay may end up to one tick early
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            lvl_q <= '0;
            for (int k = 0; k < NUM_DELAYED; k++) begin
                dly_cnt_q[k] <= 15'h0;
            end
        end else begin
            for (int k = 0; k < NUM_DELAYED; k++) begin
                if (active[k] == lvl_q[k]) begin
                    dly_cnt_q[k] <= 15'h0;
                end else if (dly_cnt_q[k] >= (active[k] ? on_dly_q[k] : off_dly_q[k])) begin
                    lvl_q[k]     <= active[k];
                    dly_cnt_q[k] <= 15'h0;
                end else if (dtick_q) begin
                    dly_cnt_q[k] <= dly_cnt_q[k] + 15'h1;
                end
            end
            lvl_q[NUM_INPUTS-1:NUM_DELAYED] <= active[NUM_INPUTS-1:NUM_DELAYED];
        end
    end

    // Hold on third input; first two carry the commands
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            fwd_prev_q  <= 1'b0;
            rev_prev_q  <= 1'b0;
            latch_run_q <= 1'b0;
            latch_rev_q <= 1'b0;
        end else begin
            fwd_prev_q <= lvl_q[0];
            rev_prev_q <= lvl_q[1];
            if (!lvl_q[2] || mode_q == TDC_TWO_LINE_1 || mode_q == TDC_TWO_LINE_2) begin
                latch_run_q <= 1'b0;
                latch_rev_q <= 1'b0;
            end else if (mode_q == TDC_THREE_LINE_1) begin
                // Simultaneous presses are ambiguous and change nothing
                if (lvl_q[0] && !fwd_prev_q && !(lvl_q[1] && !rev_prev_q)) begin
                    latch_run_q <= 1'b1;
                    latch_rev_q <= 1'b0;
                end else if (lvl_q[1] && !rev_prev_q && !(lvl_q[0] && !fwd_prev_q)) begin
                    latch_run_q <= 1'b1;
                    latch_rev_q <= 1'b1;
                end
            end else if (lvl_q[0] && !fwd_prev_q) begin
                latch_run_q <= 1'b1;
            end
        end
    end

    always_comb begin
        run_d = 1'b0;
        rev_d = 1'b0;
        case (tdc_mode_t'(mode_q))
            TDC_TWO_LINE_1: begin
                run_d = lvl_q[0] ^ lvl_q[1];
                rev_d = lvl_q[1] && !lvl_q[0];
            end
            TDC_TWO_LINE_2: begin
                run_d = lvl_q[0];
                rev_d = lvl_q[0] && lvl_q[1];
            end
            TDC_THREE_LINE_1: begin
                run_d = latch_run_q && lvl_q[2];
                rev_d = run_d && latch_rev_q;
            end
            TDC_THREE_LINE_2: begin
                run_d = latch_run_q && lvl_q[2];
                rev_d = run_d && lvl_q[1];
            end
            default: begin
                run_d = 1'b0;
                rev_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            run_o     <= 1'b0;
            reverse_o <= 1'b0;
        end else begin
            run_o     <= run_d;
            reverse_o <= rev_d;
        end
    end

    // Ramp: fourth input raises, fifth lowers, in micro-hertz per millisecond
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            rtick_cnt_q <= 25'h0;
            rtick_q     <= 1'b0;
        end else if (rtick_cnt_q == 25'(RAMP_TICK_CYCLES - 1)) begin
            rtick_cnt_q <= 25'h0;
            rtick_q     <= 1'b1;
        end else begin
            rtick_cnt_q <= rtick_cnt_q + 25'h1;
            rtick_q     <= 1'b0;
        end
    end

    assign step    = (res_q == RES_COARSE) ? 20'({4'h0, rate_q} * 20'h0000A)
                                           : {4'h0, rate_q};
    assign freq_up = {1'b0, freq_ref_o} + {13'h0, step};

    // Clamps at the ceiling and at zero instead of wrapping
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            freq_ref_o <= 32'h0000_0000;
        end else if (rtick_q && lvl_q[3] && !lvl_q[4]) begin
            freq_ref_o <= (freq_up > {1'b0, FREQ_MAX_UHZ}) ? FREQ_MAX_UHZ : freq_up[31:0];
        end else if (rtick_q && lvl_q[4] && !lvl_q[3]) begin
            freq_ref_o <= (freq_ref_o < {12'h0, step}) ? 32'h0 : freq_ref_o - {12'h0, step};
        end
    end
endmodule
`default_nettype wire

// >>> verif/tdc_props.sv
// Port checker for the terminal run-command decoder.
// Assumes delays stay zero until written; shadows mode and polarity.
`timescale 1ns/10ps
`default_nettype none
module tdc_props (
    input wire logic        ref_clk_i,
    input wire logic        resetn_i,
    input wire logic [9:0]  din_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic        avs_waitrequest_o,
    input wire logic        run_o,
    input wire logic        reverse_o
);
    logic [1:0] mode_q;
    logic [2:0] pol_q;
    logic [9:0] din_q;
    logic [3:0] cnt_q;
    logic       dly_q;
    logic       wr;
    logic [2:0] act;
    logic       st;
    assign wr  = avs_write_i && !avs_waitrequest_o;
    assign act = din_i[2:0] ~^ pol_q;
    assign st  = cnt_q == 4'hA && !dly_q;
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            mode_q <= 2'h0;
            pol_q  <= 3'h0;
            dly_q  <= 1'b0;
        end else if (wr) begin
            if (avs_address_i == 8'h00) mode_q <= avs_writedata_i[1:0];
            if (avs_address_i == 8'h08) pol_q <= avs_writedata_i[2:0];
            if (avs_address_i >= 8'h20 && avs_writedata_i != 32'h0) dly_q <= 1'b1;
        end
    end
    // Level checks are judged only once inputs and settings sat still long enough
    always_ff @(posedge ref_clk_i) begin
        din_q <= din_i;
        if (!resetn_i || wr || din_i != din_q) cnt_q <= 4'h0;
        else if (cnt_q != 4'hA) cnt_q <= cnt_q + 4'h1;
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    a_two_line_run: assert property (
        st && mode_q == 2'h0 && act[0] != act[1] |-> run_o && reverse_o == act[1])
        else $error("two-line run wrong");
    a_two_line_stop: assert property (
        st && mode_q == 2'h0 && act[0] == act[1] |-> !run_o) else $error("two-line stop");
    a_enable_dir: assert property (
        st && mode_q == 2'h1 && act[0] |-> run_o && reverse_o == act[1])
        else $error("enable run wrong");
    a_enable_off: assert property (
        st && mode_q == 2'h1 && !act[0] |-> !run_o) else $error("enable stop");
    a_press_fwd: assert property (
        !dly_q && mode_q == 2'h2 && act == 3'b101 && $rose(act[0])
        ##1 (act[2:1] == 2'b10)[*8] |-> run_o && !reverse_o) else $error("press fwd");
    a_hold_stop: assert property (
        !dly_q && mode_q[1] && $fell(act[2]) |-> ##[1:6] !run_o) else $error("hold stop");
    a_level_dir: assert property (
        st && mode_q == 2'h3 && run_o |-> reverse_o == act[1]) else $error("level dir");
    a_run_at_press: assert property (
        !dly_q && mode_q == 2'h3 && act[2] && $rose(act[0])
        ##1 (act[2] && act[0])[*6] |-> run_o) else $error("run press");
endmodule
`default_nettype wire

// >>> verif/tdc_contacts.sv
// Switch contacts wired between the inputs and common.
// Assumes the bench sets the closed contacts just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module tdc_contacts (
    input  wire logic [9:0] closed_i,
    output logic      [9:0] din_o
);
    // Bit 2 is the hold button, bits 0 and 1 the command contacts
    assign din_o = closed_i;
endmodule
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the terminal run-command decoder.
// Assumes short tick parameters so delays and ramps end quickly.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
module testbench;
    import tdc_pkg::*;
    logic        ref_clk_i       = 1'b0;
    logic        resetn_i        = 1'b0;
    logic [9:0]  closed          = 10'h000;
    logic [7:0]  avs_address_i   = 8'h00;
    logic        avs_read_i      = 1'b0;
    logic        avs_write_i     = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [9:0]  din_i;
    logic [31:0] avs_readdata_o, freq_ref_o, rd, f0;
    logic        avs_waitrequest_o, run_o, reverse_o;
    logic [7:0]  r;
    int          errors = 0;
    int          compares = 0;
    // Mode, polarity of inputs 1..5, active inputs 3..1, run, reverse
    logic [7:0]  rows [8] = '{8'b00_0_001_10, 8'b00_1_010_11, 8'b00_0_011_00, 8'b00_1_000_00,
                              8'b01_0_001_10, 8'b01_1_011_11, 8'b01_0_010_00, 8'b01_1_000_00};
    logic [39:0] regs [6] = '{{OFF_CTRL, 32'h0000_0020}, {OFF_RATE, 32'h0000_03E8},
                              {OFF_POL_LO, 32'h0}, {OFF_POL_HI, 32'h0},
                              {OFF_DELAY_LAST, 32'h0}, {8'h18, 32'h0}};
    tdc_contacts i_sw (.closed_i(closed), .din_o(din_i));
    tdc_terminal_decoder #(.DELAY_TICK_CYCLES(10), .RAMP_TICK_CYCLES(5)) i_dut (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .din_i(din_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .run_o(run_o), .reverse_o(reverse_o), .freq_ref_o(freq_ref_o));
    always #20 ref_clk_i = ~ref_clk_i;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= w;
        avs_read_i      <= !w;
        do @(posedge ref_clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
    endtask
    task automatic sw(input logic [9:0] c, input int n);
        @(posedge ref_clk_i);
        closed <= c;
        repeat (n) @(posedge ref_clk_i);
    endtask
    // Step size seen between two successive reference updates
    task automatic ramp(input logic [31:0] s);
        @(posedge ref_clk_i);
        f0 = freq_ref_o;
        do @(posedge ref_clk_i); while (freq_ref_o === f0);
        `CHK(freq_ref_o - f0, s)
    endtask
    task automatic complete_run;
        $display("Errors %0d, compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        errors++;
        complete_run();
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        foreach (regs[i]) begin
            bus(1'b0, regs[i][39:32], 32'h0);
            `CHK(rd, regs[i][31:0])
        end
        foreach (rows[i]) begin
            r = rows[i];
            bus(1'b1, OFF_CTRL, {26'h0, RES_RST, 2'h0, r[7:6]});
            bus(1'b1, OFF_POL_LO, {27'h0, {5{r[5]}}});
            sw({7'h00, r[4:2] ~^ {3{r[5]}}}, 12);
            `CHK({run_o, reverse_o}, r[1:0])
        end
        bus(1'b1, OFF_CTRL, 32'h0000_0022);
        sw(10'h004, 8);
        `CHK(run_o, 1'b0)
        sw(10'h005, 3);
        sw(10'h004, 8);
        `CHK({run_o, reverse_o}, 2'b10)
        sw(10'h006, 3);
        sw(10'h004, 8);
        `CHK({run_o, reverse_o}, 2'b11)
        sw(10'h000, 6);
        `CHK(run_o, 1'b0)
        sw(10'h001, 3);
        sw(10'h000, 8);
        `CHK(run_o, 1'b0)
        bus(1'b1, OFF_CTRL, 32'h0000_0023);
        sw(10'h006, 8);
        sw(10'h007, 7);
        `CHK({run_o, reverse_o}, 2'b11)
        sw(10'h005, 8);
        `CHK({run_o, reverse_o}, 2'b10)
        sw(10'h004, 8);
        `CHK(run_o, 1'b1)
        sw(10'h000, 6);
        `CHK(run_o, 1'b0)
        sw(10'h008, 10);
        ramp(32'h0000_03E8);
        bus(1'b1, OFF_RATE, 32'h0000_FFFF);
        ramp(32'h0000_FFFF);
        bus(1'b1, OFF_RATE, 32'h0000_0007);
        bus(1'b1, OFF_CTRL, 32'h0000_0013);
        ramp(32'h0000_0046);
        sw(10'h010, 10);
        ramp(32'hFFFF_FFBA);
        // Second reset in mid-run must clear the reference
        resetn_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        `CHK({freq_ref_o, run_o, avs_waitrequest_o}, 34'h1)
        resetn_i <= 1'b1;
        bus(1'b1, OFF_POL_HI, 32'h0000_0015);
        bus(1'b0, OFF_POL_HI, 32'h0);
        `CHK(rd, 32'h0000_0015)
        sw(10'h000, 8);
        bus(1'b0, OFF_STATUS, 32'h0);
        `CHK(rd[25:21], 5'h0A)
        sw(10'h007, 8);
        bus(1'b1, OFF_DELAY_BASE, 32'h0000_0003);
        bus(1'b1, OFF_DELAY_BASE + 8'h04, 32'h0000_0002);
        sw(10'h006, 12);
        `CHK(run_o, 1'b0)
        sw(10'h006, 30);
        `CHK(run_o, 1'b1)
        sw(10'h007, 8);
        `CHK(run_o, 1'b1)
        sw(10'h007, 30);
        `CHK(run_o, 1'b0)
        bus(1'b1, OFF_DELAY_LAST, 32'h0000_7FFF);
        bus(1'b0, OFF_DELAY_LAST, 32'h0);
        `CHK(rd, {17'h0, DELAY_MAX})
        complete_run();
    end
endmodule
bind tdc_terminal_decoder tdc_props i_props (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .din_i(din_i), .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
    .run_o(run_o), .reverse_o(reverse_o));
`default_nettype wire
